/* core/gp_ctl_if.sv */
// control bundle between the register file and the pad control logic
`timescale 1ns/10ps
`default_nettype none

interface gp_ctl_if #(
  parameter int unsigned W = 8
);
  logic [W-1:0] dir;
  logic [W-1:0] drive;
  logic global_pullup_disable;
  logic [W-1:0] out_nx;
  logic [W-1:0] oe_n_nx;
  logic [W-1:0] pu_nx;

  // register side hands out settings and takes back pad values
  modport regs (
    output dir,
    output drive,
    output global_pullup_disable,
    input out_nx,
    input oe_n_nx,
    input pu_nx
  );

  // pad side turns settings into pad controls
  modport pad (
    input dir,
    input drive,
    input global_pullup_disable,
    output out_nx,
    output oe_n_nx,
    output pu_nx
  );
endinterface : gp_ctl_if

`default_nettype wire

/* core/gp_in_sync.sv */
// pin input synchroniser: clock-high latch followed by a rising-edge flop
`timescale 1ns/10ps
`default_nettype none

module gp_in_sync
  import gp_pkg::*;
#(
  parameter int unsigned W = GP_PORT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic [W-1:0] pad_in,
  input wire logic sleep_clamp,
  input wire logic [W-1:0] wake_pin_en,
  output logic [W-1:0] level_q
);

  logic [W-1:0] gated_in;
  logic [W-1:0] hold_l;
  logic [W-1:0] level_d;

  ////////////////////////////////////////////////////////////////////////////
  // deep sleep grounds floating inputs, wake pins stay live
  always_comb begin
    gated_in = pad_in & ~({W{sleep_clamp}} & ~wake_pin_en); // R17
  end

  // open while the clock is high, holds through the low phase
  always_latch begin
    if (pclk) begin
      hold_l = gated_in; // R12
    end
  end

  // the held value moves into the level bit at the next rising edge
  always_comb begin
    level_d = hold_l; // R11 R13
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= {W{GP_LEVEL_BIT_RST}};
    end else if (pce) begin
      level_q <= level_d; // R12
    end
  end

endmodule : gp_in_sync

`default_nettype wire

/* core/gp_pad_ctl.sv */
// per-pin pad control decode: drive, output enable and pull-up
`timescale 1ns/10ps
`default_nettype none

module gp_pad_ctl
  import gp_pkg::*;
#(
  parameter int unsigned W = GP_PORT_W
) (
  gp_ctl_if.pad ctl
);

  ////////////////////////////////////////////////////////////////////////////
  // each bit sees only its own settings and the global pull-up disable, so pins never disturb each other
  always_comb begin
    for (int i = 0; i < W; i++) begin
      ctl.oe_n_nx[i] = ~ctl.dir[i]; // R1 R16
      ctl.out_nx[i] = ctl.drive[i]; // R5
      // pull-up only as input with value one, killed by the global disable
      ctl.pu_nx[i] = ~ctl.dir[i] & ctl.drive[i] & ~ctl.global_pullup_disable; // R2 R3 R8
    end
  end

endmodule : gp_pad_ctl

`default_nettype wire

/* core/gp_pkg.sv */
// shared constants for the general-purpose port block
package gp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int unsigned GP_PORT_W = 8;
  localparam int unsigned GP_ADDR_W = 8;
  localparam int unsigned GP_DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets, one aligned word each
  localparam logic [7:0] GP_OFF_LEVEL = 8'h00;
  localparam logic [7:0] GP_OFF_DIR = 8'h04;
  localparam logic [7:0] GP_OFF_DRIVE = 8'h08;
  localparam logic [7:0] GP_OFF_CTRL = 8'h0c;
  localparam logic [7:0] GP_OFF_DIR_SET = 8'h10;
  localparam logic [7:0] GP_OFF_DIR_CLR = 8'h14;
  localparam logic [7:0] GP_OFF_DRV_SET = 8'h18;
  localparam logic [7:0] GP_OFF_DRV_CLR = 8'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int unsigned GP_CTRL_PUD_POS = 0;
  localparam logic GP_DIR_BIT_RST = 1'b0;
  localparam logic GP_DRIVE_BIT_RST = 1'b0;
  localparam logic GP_PUD_RST = 1'b0;
  localparam logic GP_OE_N_BIT_RST = 1'b1;
  localparam logic GP_PULLUP_BIT_RST = 1'b0;
  localparam logic GP_LEVEL_BIT_RST = 1'b0;

endpackage : gp_pkg

/* core/gp_port.sv */
// general-purpose bidirectional port with apb register access
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1 - direction bit one makes the pin an output, zero an input
// R2 - input with drive value one enables the pull-up unless globally disabled
// R3 - pull-up off when drive value is zero or the pin is an output
// R4 - reset tri-states every pin at once, without any clock
// R5 - output pin is driven to its drive value bit
// R6 - writing one to a sampled-level bit inverts that drive value bit
// R7 - three port locations: drive value, direction, read-only sampled level
// R8 - global pull-up disable kills every pull-up in the port
// R9 - software steps via pull-up or output-low between tri-state and high
// R10 - software steps via tri-state or output-high between pull-up and low
// R11 - sampled level follows the pin whatever the direction, via synchroniser
// R12 - latch open while clock high, flop loads it on next rising edge
// R13 - pin change reaches the level bit after at least half a period
// R14 - written output value needs one period before it can be read back
// R15 - single-bit set and clear touch only the addressed pin
// R16 - pins taken by other functions leave the rest usable
// R17 - deep sleep clamps inputs low except on wake-enabled pins
// R18 - eight-bit port registers, direction and drive value reset to zero
module gp_port
  import gp_pkg::*;
#(
  parameter int unsigned W = GP_PORT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [GP_ADDR_W-1:0] paddr,
  input wire logic [GP_DATA_W-1:0] pwdata,
  output logic [GP_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [W-1:0] pad_in,
  output logic [W-1:0] pad_out,
  output logic [W-1:0] pad_oe_n,
  output logic [W-1:0] pad_pullup_en,
  input wire logic sleep_clamp,
  input wire logic [W-1:0] wake_pin_en
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // true when the address names one of the port locations
  function automatic logic gp_mapped(input logic [GP_ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      GP_OFF_LEVEL,
      GP_OFF_DIR,
      GP_OFF_DRIVE,
      GP_OFF_CTRL,
      GP_OFF_DIR_SET,
      GP_OFF_DIR_CLR,
      GP_OFF_DRV_SET,
      GP_OFF_DRV_CLR: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : gp_mapped

  // widen a port-sized value to a bus word, upper bits read as zero
  function automatic logic [GP_DATA_W-1:0] gp_word(input logic [W-1:0] v);
    logic [GP_DATA_W-1:0] w;
    w = '0;
    w[W-1:0] = v;
    return w;
  endfunction : gp_word

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  // register state
  logic [W-1:0] dir_q;
  logic [W-1:0] dir_d;
  logic [W-1:0] drive_q;
  logic [W-1:0] drive_d;
  logic pud_q;
  logic pud_d;

  // bus side
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [GP_DATA_W-1:0] prdata_q;
  logic [GP_DATA_W-1:0] prdata_d;

  // pad side
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;
  logic [W-1:0] oe_n_q;
  logic [W-1:0] oe_n_d;
  logic [W-1:0] pu_q;
  logic [W-1:0] pu_d;

  logic [W-1:0] level_q;
  logic access;
  logic first_acc;
  logic commit_wr;
  logic [W-1:0] wbits;
  logic [GP_DATA_W-1:0] rd_word;

  gp_ctl_if #(.W(W)) ctl ();

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake
  // pready comes from a flop, so with pce high every access phase lasts exactly two
  // cycles; the extra cycle buys registered outputs on the bus side

  // phase decode; a write needs pready already high
  always_comb begin
    access = psel & penable;
    first_acc = access & ~pready_q;
    commit_wr = access & pready_q & pwrite & gp_mapped(paddr);
    wbits = pwdata[W-1:0];
  end

  // read word picked while the access phase opens
  always_comb begin
    rd_word = '0;
    case (paddr)
      GP_OFF_LEVEL: begin
        rd_word = gp_word(level_q); // R7 R11
      end
      GP_OFF_DIR: begin
        rd_word = gp_word(dir_q);
      end
      GP_OFF_DRIVE: begin
        rd_word = gp_word(drive_q);
      end
      GP_OFF_CTRL: begin
        rd_word[GP_CTRL_PUD_POS] = pud_q;
      end
      default: begin
        rd_word = '0; // strobe locations and holes read zero
      end
    endcase
  end

  // one wait state: answer one cycle after the access phase opens
  always_comb begin
    pready_d = first_acc;
    pslverr_d = first_acc & ~gp_mapped(paddr);
    prdata_d = prdata_q;
    if (first_acc & ~pwrite) begin
      prdata_d = rd_word;
    end
  end

  // bus flops; pce low stalls a transfer in place
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (pce) begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port registers
  // a write lands only at the edge where pready is seen high; the
  // sampled-level location stores nothing, a one there flips drive value

  // next register values, held unless a write commits
  always_comb begin
    dir_d = dir_q;
    drive_d = drive_q;
    pud_d = pud_q;
    if (commit_wr) begin
      case (paddr)
        GP_OFF_DIR: begin
          dir_d = wbits; // R1
        end
        GP_OFF_DRIVE: begin
          drive_d = wbits; // R5
        end
        GP_OFF_LEVEL: begin
          drive_d = drive_q ^ wbits; // R6 R7
        end
        GP_OFF_CTRL: begin
          pud_d = pwdata[GP_CTRL_PUD_POS]; // R8
        end
        GP_OFF_DIR_SET: begin
          dir_d = dir_q | wbits; // R15
        end
        GP_OFF_DIR_CLR: begin
          dir_d = dir_q & ~wbits; // R15
        end
        GP_OFF_DRV_SET: begin
          drive_d = drive_q | wbits; // R15
        end
        GP_OFF_DRV_CLR: begin
          drive_d = drive_q & ~wbits; // R15
        end
        default: begin
          dir_d = dir_q;
        end
      endcase
    end
  end

  // direction and drive value start at zero: every pin an input, no pull-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= {W{GP_DIR_BIT_RST}}; // R18
      drive_q <= {W{GP_DRIVE_BIT_RST}}; // R18
      pud_q <= GP_PUD_RST;
    end else if (pce) begin
      dir_q <= dir_d;
      drive_q <= drive_d;
      pud_q <= pud_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad controls
  // the decode looks at next register values so the pads change on the
  // same edge as the register; a written level then reaches the level
  // bit one period later, which software covers with one idle slot

  // next values handed to the decode
  always_comb begin
    ctl.dir = dir_d;
    ctl.drive = drive_d;
    ctl.global_pullup_disable = pud_d;
  end

  // per-pin decode, one bit slice each
  gp_pad_ctl #(
    .W(W)
  ) u_pad_ctl (
    .ctl(ctl.pad)
  );

  // decoded pad values into the pad flops
  always_comb begin
    out_d = ctl.out_nx; // R5
    oe_n_d = ctl.oe_n_nx; // R1
    pu_d = ctl.pu_nx; // R2 R3 R8
  end

  // asynchronous reset releases the pads even with the clock stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= {W{GP_DRIVE_BIT_RST}};
      oe_n_q <= {W{GP_OE_N_BIT_RST}}; // R4
      pu_q <= {W{GP_PULLUP_BIT_RST}}; // R4
    end else if (pce) begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      pu_q <= pu_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin input path
  // the pad level is read back even while driven, so a short on an
  // output pin shows up in the sampled-level register

  gp_in_sync #(
    .W(W)
  ) u_in_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .pad_in(pad_in),
    .sleep_clamp(sleep_clamp),
    .wake_pin_en(wake_pin_en),
    .level_q(level_q) // R11 R14
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  // plain copies, no gate between flop and pin
  always_comb begin
    prdata = prdata_q;
    pready = pready_q;
    pslverr = pslverr_q;
    pad_out = out_q;
    pad_oe_n = oe_n_q;
    pad_pullup_en = pu_q;
  end

endmodule : gp_port

`default_nettype wire

/* tb/gp_pin_model.sv */
// pin-side model: board drivers, pull-ups and floating pins
`timescale 1ns/10ps
`default_nettype none
module gp_pin_model (
  input wire logic pclk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pad_pullup_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  logic flt_q = 1'b0;
  // a loose pin wanders, so a stale level is never trusted
  always @(posedge pclk) begin
    flt_q <= ~flt_q;
  end
  // resolve each pin from all drivers
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pullup_en[i]) pad_in[i] = 1'b1;
      else pad_in[i] = flt_q;
    end
  end
endmodule : gp_pin_model
`default_nettype wire

/* tb/gp_port_sva.sv */
// assertion checker for the port
`timescale 1ns/10ps
`default_nettype none
module gp_port_sva
  import gp_pkg::*;
#(parameter int unsigned W = GP_PORT_W) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [GP_ADDR_W-1:0] paddr,
  input wire logic [GP_DATA_W-1:0] pwdata,
  input wire logic [GP_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [W-1:0] pad_in,
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe_n,
  input wire logic [W-1:0] pad_pullup_en,
  input wire logic sleep_clamp,
  input wire logic [W-1:0] wake_pin_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  // commit edge of a transfer
  assign acc = psel && penable && pready && pce;
  sequence s_wr(logic [7:0] a);
    acc && pwrite && paddr == a;
  endsequence
  // pin must settle before the level flop can be trusted
  sequence s_quiet;
    (pce && !sleep_clamp && $stable(pad_in))[*3];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  property p_rst;
    disable iff (1'b0) !presetn |-> &pad_oe_n;
  endproperty
  a_rst: assert property (p_rst) else $error("pads driven in reset");
  property p_dir;
    s_wr(GP_OFF_DIR) |=> pad_oe_n == ~$past(pwdata[W-1:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_drv;
    s_wr(GP_OFF_DRIVE) |=> pad_out == $past(pwdata[W-1:0]);
  endproperty
  a_drv: assert property (p_drv) else $error("drive value not applied");
  property p_tgl;
    s_wr(GP_OFF_LEVEL) |=> pad_out == ($past(pad_out) ^ $past(pwdata[W-1:0]));
  endproperty
  a_tgl: assert property (p_tgl) else $error("toggle wrong");
  property p_pu;
    (pad_pullup_en & ~(pad_oe_n & pad_out)) == '0;
  endproperty
  a_pu: assert property (p_pu) else $error("pull-up on output or low");
  property p_pud;
    s_wr(GP_OFF_CTRL) ##0 pwdata[GP_CTRL_PUD_POS] |=> pad_pullup_en == '0;
  endproperty
  a_pud: assert property (p_pud) else $error("pull-up survives disable");
  property p_set;
    s_wr(GP_OFF_DIR_SET) |=> pad_oe_n == ($past(pad_oe_n) & ~$past(pwdata[W-1:0]));
  endproperty
  a_set: assert property (p_set) else $error("set touched other pins");
  property p_lvl;
    s_quiet ##0 (acc && !pwrite && paddr == GP_OFF_LEVEL) |-> prdata[W-1:0] == pad_in;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level differs from pin");
  property p_err;
    acc |-> pslverr == (paddr > GP_OFF_DRV_CLR || paddr[1:0] != 2'b00);
  endproperty
  a_err: assert property (p_err) else $error("error flag wrong");
endmodule : gp_port_sva
bind gp_port gp_port_sva #(.W(W)) i_sva (.*);
`default_nettype wire

/* tb/test_bidir_port_pin_logic.sv */
// self-checking bench for the port
`timescale 1ns/10ps
`default_nettype none
module test_bidir_port_pin_logic
  import gp_pkg::*;
;
  logic pclk = 0, presetn = 1, pce = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, er, sleep_clamp = 0;
  logic [7:0] paddr = 8'h00, wake_pin_en = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
  logic [7:0] pad_in, pad_out, pad_oe_n, pad_pullup_en;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int miscompares = 0, tests_run = 0;
  gp_port i_dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en),
    .sleep_clamp(sleep_clamp), .wake_pin_en(wake_pin_en));
  gp_pin_model i_pins (.pclk(pclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup_en(pad_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  initial begin
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; holds everything until pready is seen high
  // no limit of its own: only the watchdog ends a hung wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // write, then let pad updates land
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    #1;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs well under 1000 cycles
  initial begin
    #50us;
    miscompares++;
    results();
  end
  initial begin
    // a real falling edge, so the pads go quiet before any clock
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    chk(pad_oe_n, 8'hff);
    presetn <= 1'b1;
    pce <= 1'b1;
    rdc(GP_OFF_DIR, 0);
    rdc(GP_OFF_DRIVE, 0);
    rdc(GP_OFF_CTRL, 0);
    $display("test reset done");
    // direction first so pins step through output low
    wr(GP_OFF_DIR, 32'h0f);
    wr(GP_OFF_DRIVE, 32'h33);
    chk(pad_oe_n, 8'hf0);
    chk(pad_out & ~pad_oe_n, 8'h03);
    chk(pad_pullup_en, 8'h30);
    rdc(GP_OFF_DIR, 32'h0f);
    ext_en <= 8'hc0;
    ext_val <= 8'h80;
    rdc(GP_OFF_LEVEL, 32'hb3);
    $display("test config done");
    wr(GP_OFF_LEVEL, 32'h8f);
    wr(GP_OFF_LEVEL, 32'h00);
    rdc(GP_OFF_DRIVE, 32'hbc);
    rdc(GP_OFF_LEVEL, 32'hbc);
    chk(pad_pullup_en, 8'hb0);
    wr(GP_OFF_CTRL, 32'h1);
    chk(pad_pullup_en, 8'h00);
    wr(GP_OFF_CTRL, 32'h0);
    chk(pad_pullup_en, 8'hb0);
    $display("test toggle done");
    wr(GP_OFF_DIR_SET, 32'h40);
    wr(GP_OFF_DIR_CLR, 32'h01);
    wr(GP_OFF_DRV_SET, 32'h02);
    wr(GP_OFF_DRV_CLR, 32'h80);
    rdc(GP_OFF_DIR, 32'h4e);
    rdc(GP_OFF_DRIVE, 32'h3e);
    rdc(GP_OFF_DIR_SET, 0);
    apb(1'b1, 8'h20, 32'hff);
    chk(er, 1'b1);
    apb(1'b0, 8'h22, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    rdc(GP_OFF_DIR, 32'h4e);
    $display("test set clear done");
    // pin 5 from pull-up input to output low by way of tri-state
    wr(GP_OFF_DRV_CLR, 32'h20);
    wr(GP_OFF_DIR_SET, 32'h20);
    chk(pad_oe_n, 8'h91);
    chk(pad_out, 8'h1e);
    chk(pad_pullup_en, 8'h10);
    // clock enable low stalls a write until it returns
    @(posedge pclk);
    pce <= 1'b0;
    fork
      wr(GP_OFF_DRV_SET, 32'h01);
      begin
        repeat (6) @(posedge pclk);
        chk(pad_out, 8'h1e);
        pce <= 1'b1;
      end
    join
    chk(pad_out, 8'h1f);
    $display("test hold done");
    sleep_clamp <= 1'b1;
    wake_pin_en <= 8'h80;
    rdc(GP_OFF_LEVEL, 32'h80);
    sleep_clamp <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    chk(pad_oe_n, 8'hff);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(GP_OFF_DIR, 0);
    $display("test sleep reset done");
    results();
  end
endmodule : test_bidir_port_pin_logic
`default_nettype wire
